/* File: hw/sfpi_pkg.sv */
// ==========================================================
// shared constants of the serial flash pin interface
package sfpi_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned POR_TIME_NS   = 1000;
  localparam int unsigned POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAGE_STD      = 528;
  localparam int unsigned PAGE_BIN      = 512;
  localparam int unsigned NUM_PAGES     = 4096;
  localparam int unsigned OTP_BYTES     = 128;
  localparam int unsigned OTP_HALF      = 64;
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [7:0]  OTP_BLANK     = 8'hFF;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_OPCODE  = 2'b01,
    ST_STREAM  = 2'b10,
    ST_DISCARD = 2'b11
  } sfpi_state_type;
endpackage

/* File: hw/sfpi_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - deselected: standby, serial output high impedance
// - deselected: serial input fully ignored
// - select edges alone frame every operation
// - standby only after internal operation finishes
// - input bits sampled on clock rising edge
// - output bits change on clock falling edge
// - protect pin blocks program/erase on mapped sectors
// - protection map frozen while protect pin low
// - protected program/erase discarded until deselect
// - protection enable and lockdown still accepted
// - floating protect pin reads as deasserted
// - reset pin low aborts and holds idle
// - own power-on reset initialises the device
// - works in clock modes 0 and 3
// - page size 528 default, 512 selectable
// - array holds 4096 pages
// - two independent page buffers
// - program and erase timed internally
// - 128-byte one-time area, half factory, half user
// - first byte after select is the opcode
// - bytes travel most significant bit first

// ==========================================================
// fifo between the serial front end and the page buffers
module sfpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // system
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             full;
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && !full) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (out_valid && out_ready) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // sfpi_fifo

// ==========================================================
// pin-level front end of the serial flash
module sfpi_top #(
  parameter int          SECTORS      = 16,
  parameter int          OP_CYCLES    = 64,
  parameter bit          FACTORY_512  = 1'b0,
  parameter logic [7:0]  FACTORY_ID   = 8'h5A  // arbitrary identifier seed
) (
  // system
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // serial pins
  input  wire logic                 cs_n,
  input  wire logic                 sck,
  input  wire logic                 si,
  output logic                      so_o,
  output logic                      so_oe,
  input  wire logic                 reset_pin_n,
  input  wire logic                 wp_n_in,
  input  wire logic                 wp_n_driven,
  // command decode from the core
  output logic                      cmd_valid,
  output logic [7:0]                cmd_opcode,
  input  wire logic                 cmd_is_modify,
  input  wire logic                 cmd_is_prot,
  input  wire logic [$clog2(SECTORS)-1:0] cmd_sector,
  output logic                      cmd_rejected,
  // operation control
  input  wire logic                 op_start,
  input  wire logic                 op_buf,
  output logic                      busy,
  output logic                      standby,
  output logic                      por_done,
  // transmit byte and page buffers
  input  wire logic [7:0]           tx_data,
  input  wire logic                 buf_sel,
  input  wire logic [9:0]           buf_raddr,
  output logic [7:0]                buf_rdata,
  output logic                      rx_overflow,
  // configuration
  input  wire logic                 page_cfg_wr,
  input  wire logic                 page_cfg_512,
  output logic [9:0]                page_size,
  input  wire logic                 map_wr,
  input  wire logic [SECTORS-1:0]   map_wdata,
  output logic [SECTORS-1:0]        prot_map,
  input  wire logic                 otp_wr,
  input  wire logic [5:0]           otp_addr,
  input  wire logic [7:0]           otp_wdata,
  input  wire logic [6:0]           otp_raddr,
  output logic [7:0]                otp_rdata
);
  // ========================================================
  // pin synchronisers
  logic [1:0] cs_s_r, sck_s_r, si_s_r, rp_s_r, wp_s_r;
  logic       sck_d_r, cs_d_r;
  logic       wp_raw;
  assign wp_raw = wp_n_driven ? wp_n_in : 1'b1;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs_s_r  <= 2'b11;
      sck_s_r <= 2'b00;
      si_s_r  <= 2'b00;
      rp_s_r  <= 2'b11;
      wp_s_r  <= 2'b11;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      cs_s_r  <= {cs_s_r[0], cs_n};
      sck_s_r <= {sck_s_r[0], sck};
      si_s_r  <= {si_s_r[0], si};
      rp_s_r  <= {rp_s_r[0], reset_pin_n};
      wp_s_r  <= {wp_s_r[0], wp_raw};
      sck_d_r <= sck_s_r[1];
      cs_d_r  <= cs_s_r[1];
    end
  end
  logic sel, sck_rise, sck_fall, cs_fall, cs_rise, wp_low, pin_rst;
  assign sel      = !cs_s_r[1];
  assign sck_rise = sel && sck_s_r[1] && !sck_d_r;
  assign sck_fall = sel && !sck_s_r[1] && sck_d_r;
  assign cs_fall  = cs_d_r && !cs_s_r[1];
  assign cs_rise  = !cs_d_r && cs_s_r[1];
  assign wp_low   = !wp_s_r[1];
  // ========================================================
  // power-on reset and pin reset
  logic [$clog2(sfpi_pkg::POR_CYCLES+1)-1:0] por_cnt_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) por_cnt_r <= '0;
    else if (!por_done) por_cnt_r <= por_cnt_r + 1'b1;
  end
  assign por_done = (por_cnt_r == ($bits(por_cnt_r))'(sfpi_pkg::POR_CYCLES));
  assign pin_rst  = !rp_s_r[1] || !por_done;
  // ========================================================
  // serial shifter and framing
  sfpi_pkg::sfpi_state_type state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic       byte_done, fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data, rx_byte;
  assign rx_byte   = {rx_sh_r[6:0], si_s_r[1]};
  assign byte_done = sck_rise && (bit_cnt_r == sfpi_pkg::BIT_LAST[2:0]);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= sfpi_pkg::ST_IDLE;
    end else if (pin_rst || !sel) begin
      state_r <= sfpi_pkg::ST_IDLE;
    end else begin
      case (state_r)
        sfpi_pkg::ST_IDLE:    if (cs_fall) state_r <= sfpi_pkg::ST_OPCODE;
        sfpi_pkg::ST_OPCODE:  if (byte_done) begin
          if (cmd_is_modify && wp_low && !cmd_is_prot) state_r <= sfpi_pkg::ST_DISCARD;
          else state_r <= sfpi_pkg::ST_STREAM;
        end
        sfpi_pkg::ST_STREAM:  state_r <= sfpi_pkg::ST_STREAM;
        sfpi_pkg::ST_DISCARD: state_r <= sfpi_pkg::ST_DISCARD;
        default:              state_r <= sfpi_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= '0;
      rx_sh_r   <= sfpi_pkg::BYTE_RESET;
    end else if (cs_fall || !sel) begin
      bit_cnt_r <= '0;
    end else if (sck_rise && state_r != sfpi_pkg::ST_IDLE) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      rx_sh_r   <= rx_byte;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_r <= sfpi_pkg::BYTE_RESET;
      so_o    <= 1'b0;
    end else if (!sel) begin
      tx_sh_r <= sfpi_pkg::BYTE_RESET;
    end else if (byte_done) begin
      tx_sh_r <= tx_data;
    end else if (sck_fall) begin
      so_o    <= tx_sh_r[7];
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end
  assign so_oe = sel && !pin_rst;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid    <= 1'b0;
      cmd_opcode   <= sfpi_pkg::BYTE_RESET;
      cmd_rejected <= 1'b0;
    end else begin
      cmd_valid    <= byte_done && state_r == sfpi_pkg::ST_OPCODE && !pin_rst;
      cmd_rejected <= byte_done && state_r == sfpi_pkg::ST_OPCODE && !pin_rst
                      && cmd_is_modify && wp_low && !cmd_is_prot;
      if (byte_done && state_r == sfpi_pkg::ST_OPCODE) cmd_opcode <= rx_byte;
    end
  end
  // ========================================================
  // stream fifo into the page buffers
  logic fifo_push, drain;
  assign fifo_push = byte_done && state_r == sfpi_pkg::ST_STREAM && sel;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rx_overflow <= 1'b0;
    else if (cs_fall) rx_overflow <= 1'b0;
    else if (fifo_push && !fifo_in_ready) rx_overflow <= 1'b1;
  end
  sfpi_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .flush     (pin_rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );
  // ========================================================
  // page size, two buffers and internal timer
  logic       page_512_r;
  logic [9:0] wptr_r [2];
  logic [7:0] bufmem [2][sfpi_pkg::PAGE_STD];
  logic [$clog2(OP_CYCLES+1)-1:0] op_cnt_r;
  logic       op_buf_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) page_512_r <= FACTORY_512;
    else if (page_cfg_wr && !busy) page_512_r <= page_cfg_512;
  end
  assign page_size = page_512_r ? 10'(sfpi_pkg::PAGE_BIN) : 10'(sfpi_pkg::PAGE_STD);
  assign drain = !(busy && op_buf_r == buf_sel);
  always_ff @(posedge sys_clk) begin
    if (fifo_out_valid && drain) bufmem[buf_sel][wptr_r[buf_sel]] <= fifo_out_data;
    buf_rdata <= bufmem[buf_sel][buf_raddr];
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_r[0] <= '0;
      wptr_r[1] <= '0;
    end else if (cs_fall) begin
      wptr_r[buf_sel] <= '0;
    end else if (fifo_out_valid && drain) begin
      wptr_r[buf_sel] <= (wptr_r[buf_sel] == page_size - 10'h001) ? 10'h000 : wptr_r[buf_sel] + 10'h001;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      op_cnt_r <= '0;
      op_buf_r <= 1'b0;
    end else if (pin_rst) begin
      op_cnt_r <= '0;
    end else if (op_start && !busy && !(wp_low && prot_map[cmd_sector])) begin
      op_cnt_r <= ($bits(op_cnt_r))'(OP_CYCLES);
      op_buf_r <= op_buf;
    end else if (busy) begin
      op_cnt_r <= op_cnt_r - 1'b1;
    end
  end
  assign busy    = (op_cnt_r != '0);
  assign standby = !sel && !busy;
  // ========================================================
  // protection map and one-time area
  logic [7:0] otp_user [sfpi_pkg::OTP_HALF];
  logic [sfpi_pkg::OTP_HALF-1:0] otp_used_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) prot_map <= '0;
    else if (map_wr && !wp_low) prot_map <= map_wdata;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) otp_used_r <= '0;
    else if (otp_wr) otp_used_r[otp_addr] <= 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (otp_wr && !otp_used_r[otp_addr]) otp_user[otp_addr] <= otp_wdata;
    if (otp_raddr[6]) otp_rdata <= otp_used_r[otp_raddr[5:0]] ? otp_user[otp_raddr[5:0]] : sfpi_pkg::OTP_BLANK;
    else otp_rdata <= FACTORY_ID ^ {2'b00, otp_raddr[5:0]};
  end
  // ========================================================
  // checks
  sequence s_byte_in;
    byte_done && state_r == sfpi_pkg::ST_OPCODE && !pin_rst;
  endsequence
  property p_hiz_deselect;
    @(posedge sys_clk) disable iff (!rstn) cs_s_r[1] |-> !so_oe;
  endproperty
  a_hiz_deselect: assert property (p_hiz_deselect) else $error("output driven while deselected");
  property p_no_push_idle;
    @(posedge sys_clk) disable iff (!rstn) !sel |=> !fifo_push && state_r == sfpi_pkg::ST_IDLE && bit_cnt_r == 3'h0;
  endproperty
  a_no_push_idle: assert property (p_no_push_idle) else $error("input accepted while deselected");
  property p_opcode_strobe;
    @(posedge sys_clk) disable iff (!rstn) s_byte_in |=> cmd_valid && cmd_opcode == $past(rx_byte);
  endproperty
  a_opcode_strobe: assert property (p_opcode_strobe) else $error("opcode not reported");
  property p_busy_standby;
    @(posedge sys_clk) disable iff (!rstn) busy |-> !standby;
  endproperty
  a_busy_standby: assert property (p_busy_standby) else $error("standby during internal operation");
  property p_so_on_fall;
    @(posedge sys_clk) disable iff (!rstn) (so_o != $past(so_o)) |-> $past(sck_fall);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off a falling edge");
  property p_map_frozen;
    @(posedge sys_clk) disable iff (!rstn) wp_low |=> $stable(prot_map);
  endproperty
  a_map_frozen: assert property (p_map_frozen) else $error("map changed while protected");
  property p_discard;
    @(posedge sys_clk) disable iff (!rstn) s_byte_in ##0 (cmd_is_modify && wp_low && !cmd_is_prot && sel)
      |=> cmd_rejected && state_r == sfpi_pkg::ST_DISCARD;
  endproperty
  a_discard: assert property (p_discard) else $error("protected command not discarded");
  property p_pin_reset;
    @(posedge sys_clk) disable iff (!rstn) pin_rst |=> !busy && state_r == sfpi_pkg::ST_IDLE;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset did not abort");
  property p_timed_op;
    @(posedge sys_clk) disable iff (!rstn) ($rose(busy) ##1 !pin_rst [*3]) |-> busy;
  endproperty
  a_timed_op: assert property (p_timed_op) else $error("internal operation ended early");
endmodule // sfpi_top

/* File: sim/sfpi_host.sv */
`timescale 1ns/100ps
// ==========================================================
// spi host model driving the flash pins
module sfpi_host (
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe
);
  localparam int HALF = 80;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // one frame of two bytes, sck held still while cs moves
  task automatic xfer(input logic mode3, input logic [15:0] tx, output logic [7:0] rx, output logic oe_ok);
    rx    = 8'h00;
    oe_ok = 1'b1;
    sck   = mode3;
    #(HALF);
    cs_n = 1'b0;
    #(HALF);
    for (int i = 15; i >= 0; i--) begin
      sck = 1'b0;
      si  = tx[i];
      #(HALF);
      sck = 1'b1;
      if (i < 8) rx[i] = so_o;
      oe_ok &= (so_oe === 1'b1);
      #(HALF);
    end
    sck = mode3;
    #(HALF);
    cs_n = 1'b1;
    si   = ~si;
    #(HALF);
  endtask
  // deselected activity that must leave no trace
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sck = ~sck;
      si  = ~si;
      #(HALF);
    end
  endtask
endmodule // sfpi_host

/* File: sim/test_sfpi_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
// ==========================================================
// bench for the serial flash pin front end
module test_sfpi_top;
  localparam int OPC = 16;
  logic        sys_clk, rstn, cs_n, sck, si, so_o, so_oe, reset_pin_n, wp_n_in, wp_n_driven;
  logic        cmd_valid, cmd_is_modify, cmd_is_prot, cmd_rejected, op_start, op_buf, busy, standby;
  logic        por_done, buf_sel, rx_overflow, page_cfg_wr, page_cfg_512, map_wr, otp_wr, oe;
  logic [3:0]  cmd_sector;
  logic [5:0]  otp_addr;
  logic [6:0]  otp_raddr;
  logic [7:0]  cmd_opcode, tx_data, buf_rdata, otp_wdata, otp_rdata, rx, op, dat;
  logic [9:0]  buf_raddr, page_size;
  logic [15:0] map_wdata, prot_map, m;
  logic [7:0]  exp_q[$];
  int          errors, compares, rej_cnt;

  sfpi_top #(.OP_CYCLES(OPC)) dut (
    .sys_clk, .rstn, .cs_n, .sck, .si, .so_o, .so_oe, .reset_pin_n, .wp_n_in, .wp_n_driven,
    .cmd_valid, .cmd_opcode, .cmd_is_modify, .cmd_is_prot, .cmd_sector, .cmd_rejected,
    .op_start, .op_buf, .busy, .standby, .por_done, .tx_data, .buf_sel, .buf_raddr, .buf_rdata,
    .rx_overflow, .page_cfg_wr, .page_cfg_512, .page_size, .map_wr, .map_wdata, .prot_map,
    .otp_wr, .otp_addr, .otp_wdata, .otp_raddr, .otp_rdata
  );
  sfpi_host host (.cs_n, .sck, .si, .so_o, .so_oe);

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  // ==========================================================
  // monitor: each opcode seen is matched to the oldest note
  always @(negedge sys_clk) begin
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(cmd_opcode, exp_q.pop_front())
    end
    if (cmd_rejected === 1'b1) rej_cnt++;
  end

  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic frame(input logic mode3);
    op      = 8'($urandom);
    dat     = 8'($urandom);
    tx_data = 8'($urandom);
    exp_q.push_back(op);
    host.xfer(mode3, {op, dat}, rx, oe);
    tick(6);
  endtask
  task automatic pulse_op(input logic [3:0] sec);
    cmd_sector = sec;
    op_start   = 1'b1;
    tick(1);
    op_start = 1'b0;
    tick(1);
  endtask

  initial begin
    #400000;
    errors++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial begin
    {rstn, op_start, page_cfg_wr, map_wr, otp_wr, cmd_is_modify, cmd_is_prot} = '0;
    {reset_pin_n, wp_n_in, wp_n_driven, page_cfg_512} = 4'hE;
    {cmd_sector, op_buf, buf_sel, buf_raddr, tx_data, map_wdata} = '0;
    {otp_addr, otp_wdata, otp_raddr} = '0;
    errors   = 0;
    compares = 0;
    rej_cnt  = 0;
    void'($urandom(32'hF7A3));
    tick(12);
    rstn = 1'b1;
    tick(40);
    `CHK(por_done, 1'b0)
    `CHK(so_oe, 1'b0)
    `CHK(standby, 1'b1)
    `CHK(page_size, 10'h210)
    tick(15);
    `CHK(por_done, 1'b1)
    for (int k = 0; k < 2; k++) begin
      buf_sel = k[0];
      op_buf  = 1'($urandom);
      frame(k[0]);
      `CHK(rx, tx_data)
      `CHK(oe, 1'b1)
      `CHK(so_oe, 1'b0)
      `CHK(rx_overflow, 1'b0)
      buf_raddr = 10'h000;
      tick(2);
      `CHK(buf_rdata, dat)
    end
    host.noise(20);
    tick(6);
    m = (16'($urandom) | 16'h0001) & 16'hFFFD;
    map_wdata = m;
    map_wr    = 1'b1;
    tick(1);
    map_wr  = 1'b0;
    wp_n_in = 1'b0;
    tick(4);
    `CHK(prot_map, m)
    map_wdata = ~m;
    map_wr    = 1'b1;
    tick(1);
    map_wr = 1'b0;
    tick(2);
    `CHK(prot_map, m)
    cmd_is_modify = 1'b1;
    frame(1'b0);
    `CHK(rej_cnt, 1)
    cmd_is_prot = 1'b1;
    frame(1'b0);
    `CHK(rej_cnt, 1)
    {cmd_is_modify, cmd_is_prot} = 2'b00;
    pulse_op(4'h0);
    `CHK(busy, 1'b0)
    pulse_op(4'h1);
    `CHK(busy, 1'b1)
    tick(OPC + 4);
    wp_n_driven = 1'b0;
    tick(4);
    map_wr = 1'b1;
    tick(1);
    map_wr = 1'b0;
    tick(2);
    `CHK(prot_map, ~m)
    pulse_op(4'($urandom));
    `CHK(standby, 1'b0)
    tick(OPC - 4);
    `CHK(busy, 1'b1)
    for (int w = 0; w < 8 && busy === 1'b1; w++) tick(1);
    tick(1);
    `CHK(standby, 1'b1)
    pulse_op(4'($urandom));
    reset_pin_n = 1'b0;
    tick(4);
    `CHK(busy, 1'b0)
    `CHK(standby, 1'b1)
    reset_pin_n = 1'b1;
    tick(4);
    {page_cfg_wr, page_cfg_512} = 2'b11;
    tick(1);
    page_cfg_wr = 1'b0;
    tick(1);
    `CHK(page_size, 10'h200)
    otp_addr  = 6'($urandom);
    otp_wdata = 8'($urandom);
    otp_wr    = 1'b1;
    tick(1);
    otp_wr    = 1'b0;
    otp_raddr = {1'b1, otp_addr};
    tick(2);
    `CHK(otp_rdata, otp_wdata)
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule // test_sfpi_top
